/* File: rtl/ccp_top.sv */
// Function
// - both mode pins low selects serial control
// - both mode pins high selects static pins
// - serial mode gain pin low 0dB, high 6dB
// - overload flag held 512 samples, restartable
// - static clock pin low 256, high 384
// - static three-level pin sets de-emphasis or mute
// - static format pins pick one of four formats
// - static three-level pin: powerdown, 6dB, 0dB
// - mode line low plus 8 clocks: address
// - address low bits choose data or status
// - only device address 000101 selects us
// - selection holds until next address byte or leaving serial mode
// - commit byte only after eighth bit
// - data byte top bits select, low six value
// - status byte: ratio, format, DC filter
// - data group routes volume, tone, de-emphasis, power
// - ratio codes 512, 384, 256, one unused
// - three-bit audio format codes
// - DC filter bit enables high-pass filter
// - control port is write-only, never drives
// - volume code to attenuation, top codes silence
// - de-emphasis codes none, 32, 44.1, 48
// - power bits enable ADC and DAC
// - tone mode flat, min, min, max
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.svh"
module ccp_top (
  // Clock and reset
  input wire logic         clk_in,
  input wire logic         nrst_in,
  // Mode pins
  input wire logic         mode_sel_a_in,
  input wire logic         mode_sel_b_in,
  // Multi-purpose pins
  input wire logic         multi_pin_a_in,
  output logic             multi_pin_a_out,
  output logic             multi_pin_a_oe_out,
  input wire logic [1:0]   multi_pin_b_in,
  input wire logic         multi_pin_c_in,
  input wire logic [1:0]   multi_pin_d_in,
  input wire logic         multi_pin_e_in,
  // ADC level detect
  input wire logic         adc_clip_l_in,
  input wire logic         adc_clip_r_in,
  input wire logic         fs_tick_in,
  // Control outputs
  output ccp_pkg::ccp_mode_t mode_out,
  output logic [1:0]       clk_ratio_out,
  output logic [2:0]       audio_fmt_out,
  output logic             hpf_enable_out,
  output logic [5:0]       vol_atten_out,
  output logic [5:0]       vol_db_out,
  output logic             vol_silent_out,
  output logic [4:0]       bass_db_out,
  output logic [2:0]       treble_db_out,
  output logic [1:0]       deemph_sel_out,
  output logic             soft_mute_out,
  output logic [1:0]       tone_set_out,
  output logic             adc_power_on_out,
  output logic             dac_power_on_out,
  output logic             adc_gain_6db_out,
  output logic             adc_overload_flag_out
);
  import ccp_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Volume code to attenuation in dB
  function automatic logic [5:0] ccp_vol_db(input logic [5:0] c);
    if (c < 6'h02) begin
      ccp_vol_db = 6'h00;
    end else if (c >= `CCP_VOL_SIL) begin
      ccp_vol_db = `CCP_VOL_INF;
    end else begin
      ccp_vol_db = c - 6'h01;
    end
  endfunction

  // Bass boost in dB for level and tone set
  function automatic logic [4:0] ccp_bass_db(input logic [3:0] l,
                                             input logic [1:0] m);
    logic [4:0] raw;
    raw = {l, 1'b0};
    if (m == `CCP_TONE_FLAT) begin
      ccp_bass_db = 5'h00;
    end else if (m == `CCP_TONE_MAX) begin
      ccp_bass_db = (raw > `CCP_BASS_MAXC) ? `CCP_BASS_MAXC : raw;
    end else begin
      ccp_bass_db = (raw > `CCP_BASS_MINC) ? `CCP_BASS_MINC : raw;
    end
  endfunction

  // Treble in dB, flat set gives none
  function automatic logic [2:0] ccp_treb_db(input logic [1:0] t,
                                             input logic [1:0] m);
    ccp_treb_db = (m == `CCP_TONE_FLAT) ? 3'h0 : {t, 1'b0};
  endfunction

  // Static format pins to format code
  function automatic logic [2:0] ccp_static_fmt(input logic a,
                                                input logic e);
    case ({a, e})
      2'h0:    ccp_static_fmt = `CCP_FMT_MSB;
      2'h1:    ccp_static_fmt = `CCP_FMT_I2S;
      2'h2:    ccp_static_fmt = `CCP_FMT_L20;
      default: ccp_static_fmt = `CCP_FMT_L16;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  logic [9:0] pin_s1;  // First stage, read only by pin_s2
  logic [9:0] pin_s2;  // Settled pin levels

  // All static pins are slow straps, two stages are enough
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1 <= 10'h000;
      pin_s2 <= 10'h000;
    end else begin
      pin_s1 <= {mode_sel_a_in, mode_sel_b_in, multi_pin_a_in,
                 multi_pin_b_in, multi_pin_c_in, multi_pin_d_in,
                 multi_pin_e_in, 1'b0};
      pin_s2 <= pin_s1;
    end
  end

  wire       ma_s  = pin_s2[9];   // Mode pin a
  wire       mb_s  = pin_s2[8];   // Mode pin b
  wire       pa_s  = pin_s2[7];   // Format pin a
  wire [1:0] pb_s  = pin_s2[6:5]; // De-emphasis/mute level
  wire       pc_s  = pin_s2[4];   // Clock select
  wire [1:0] pd_s  = pin_s2[3:2]; // ADC level
  wire       pe_s  = pin_s2[1];   // Gain or format pin e

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  ccp_mode_t mode;       // Current mode
  ccp_mode_t next_mode;  // Decoded mode

  // Mixed levels fall into test mode
  assign next_mode = (!ma_s && !mb_s) ? CCP_SERIAL :
                     ( ma_s &&  mb_s) ? CCP_STATIC :
                                        CCP_TEST;

  // Registered mode
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode <= CCP_SERIAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------
  // Link receiver and crossing
  // ----------------------------------------

  ccp_link_if lnk ();

  // Port data line is input only, nothing drives it back
  ccp_shift u_shift (
    .ctl_port_clk_in   (multi_pin_c_in),
    .ctl_port_phase_in (multi_pin_b_in[1]),
    .ctl_port_din_in   (multi_pin_d_in[1]),
    .nrst_in           (nrst_in),
    .link              (lnk)
  );

  logic tgl_s1;  // First stage, read only by tgl_s2
  logic tgl_s2;  // Synchronised toggle
  logic tgl_s3;  // Delayed copy for edge

  // Toggle crossing; the byte word is stable for eight link clocks
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= lnk.tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  wire       ev      = tgl_s2 ^ tgl_s3;         // One byte arrived
  wire       ser     = (mode == CCP_SERIAL);    // Port active
  wire       addr_ev = ev && ser && lnk.is_addr;
  wire       data_ev = ev && ser && !lnk.is_addr;
  wire [1:0] dsel    = lnk.octet[`CCP_SEL];
  wire [5:0] dval    = lnk.octet[`CCP_VAL];
  wire       hit     = (lnk.octet[`CCP_AD_DEV] == `CCP_DEV_ADDR);
  wire [1:0] xfer    = lnk.octet[`CCP_AD_XFER];

  // ----------------------------------------
  // Selection state
  // ----------------------------------------

  ccp_sel_t sel;       // Current selection
  ccp_sel_t next_sel;  // Next selection

  // Only an address byte or leaving serial mode changes the selection
  always_comb begin
    next_sel = sel;
    if (!ser) begin
      next_sel = CCP_DESEL;
    end else if (addr_ev) begin
      case (xfer)
        `CCP_XFER_DATA: next_sel = hit ? CCP_SEL_DATA : CCP_DESEL;
        `CCP_XFER_STAT: next_sel = hit ? CCP_SEL_STAT : CCP_DESEL;
        default:        next_sel = CCP_DESEL;
      endcase
    end
  end

  // Registered selection
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel <= CCP_DESEL;
    end else begin
      sel <= next_sel;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------

  ccp_reg6_t st_reg;    // Ratio, format, DC filter
  ccp_reg6_t vol_reg;   // Volume code
  ccp_reg6_t tone_reg;  // Bass and treble
  ccp_reg6_t deem_reg;  // De-emphasis, mute, tone set
  ccp_reg6_t pwr_reg;   // Converter power

  // Status writes skip the unused ratio code entirely
  wire st_we   = data_ev && (sel == CCP_SEL_STAT) &&
                 (dsel == `CCP_SEL_STAT) &&
                 (dval[`CCP_ST_RATIO] != `CCP_RATIO_BAD);
  wire dat_ok  = data_ev && (sel == CCP_SEL_DATA);
  wire vol_we  = dat_ok && (dsel == `CCP_SEL_VOL);
  wire tone_we = dat_ok && (dsel == `CCP_SEL_TONE);
  wire deem_we = dat_ok && (dsel == `CCP_SEL_DEEM);
  wire pwr_we  = dat_ok && (dsel == `CCP_SEL_PWR);

  // Write targets; a deselected port writes nothing
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg   <= `CCP_RST_STAT;
      vol_reg  <= `CCP_RST_VOL;
      tone_reg <= `CCP_RST_TONE;
      deem_reg <= `CCP_RST_DEEM;
      pwr_reg  <= `CCP_RST_PWR;
    end else begin
      if (st_we)   st_reg   <= dval;
      if (vol_we)  vol_reg  <= dval;
      if (tone_we) tone_reg <= dval;
      if (deem_we) deem_reg <= dval;
      if (pwr_we)  pwr_reg  <= dval;
    end
  end

  // ----------------------------------------
  // Output selection
  // ----------------------------------------

  // Test mode keeps the register view with the port idle
  wire sreg = (mode != CCP_STATIC);

  wire [1:0] next_ratio = sreg ? st_reg[`CCP_ST_RATIO] :
                          pc_s ? `CCP_RATIO_384 : `CCP_RATIO_256;
  wire [2:0] next_fmt   = sreg ? st_reg[`CCP_ST_FMT] :
                          ccp_static_fmt(pa_s, pe_s);
  wire       next_hpf   = sreg && st_reg[`CCP_ST_HPF];
  wire [5:0] next_vol   = sreg ? vol_reg : 6'h00;
  wire [1:0] next_tone  = sreg ? deem_reg[`CCP_DM_TONE] : `CCP_TONE_FLAT;
  wire [1:0] next_deem  = sreg ? deem_reg[`CCP_DM_DEEM] :
                          (pb_s == `CCP_LVL_MID) ? `CCP_DEEM_441 : 2'h0;
  wire       next_mute  = sreg ? deem_reg[`CCP_DM_MUTE] :
                          (pb_s == `CCP_LVL_HIGH);
  wire       next_adc   = sreg ? pwr_reg[`CCP_PW_ADC] :
                          (pd_s != `CCP_LVL_LOW);
  wire       next_dac   = sreg ? pwr_reg[`CCP_PW_DAC] : 1'b1;
  wire       next_gain  = sreg ? pe_s :
                          (pd_s == `CCP_LVL_MID);
  wire       next_sil   = (next_vol >= `CCP_VOL_SIL);

  // ----------------------------------------
  // Overload detector
  // ----------------------------------------

  logic ovl_flag;  // Stretched overload

  ccp_ovl u_ovl (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .clip_in    (adc_clip_l_in || adc_clip_r_in),
    .fs_tick_in (fs_tick_in),
    .flag_out   (ovl_flag)
  );

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  // Every output leaves from a flop
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_out              <= CCP_SERIAL;
      clk_ratio_out         <= 2'h0;
      audio_fmt_out         <= 3'h0;
      hpf_enable_out        <= 1'b0;
      vol_atten_out         <= 6'h00;
      vol_db_out            <= 6'h00;
      vol_silent_out        <= 1'b0;
      bass_db_out           <= 5'h00;
      treble_db_out         <= 3'h0;
      deemph_sel_out        <= 2'h0;
      soft_mute_out         <= 1'b0;
      tone_set_out          <= 2'h0;
      adc_power_on_out      <= 1'b0;
      dac_power_on_out      <= 1'b0;
      adc_gain_6db_out      <= 1'b0;
      adc_overload_flag_out <= 1'b0;
      multi_pin_a_out       <= 1'b0;
      multi_pin_a_oe_out    <= 1'b0;
    end else begin
      mode_out              <= mode;
      clk_ratio_out         <= next_ratio;
      audio_fmt_out         <= next_fmt;
      hpf_enable_out        <= next_hpf;
      vol_atten_out         <= next_vol;
      vol_db_out            <= ccp_vol_db(next_vol);
      vol_silent_out        <= next_sil;
      bass_db_out           <= ccp_bass_db(tone_reg[`CCP_TN_BASS],
                                           next_tone);
      treble_db_out         <= ccp_treb_db(tone_reg[`CCP_TN_TREB],
                                           next_tone);
      deemph_sel_out        <= next_deem;
      soft_mute_out         <= next_mute;
      tone_set_out          <= next_tone;
      adc_power_on_out      <= next_adc;
      dac_power_on_out      <= next_dac;
      adc_gain_6db_out      <= next_gain;
      adc_overload_flag_out <= ovl_flag;
      // Pin a carries the flag only under serial control
      multi_pin_a_out       <= ovl_flag;
      multi_pin_a_oe_out    <= ser;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_stat_wr;
    data_ev && sel == CCP_SEL_STAT && dsel == 2'h0 &&
    dval[`CCP_ST_RATIO] != `CCP_RATIO_BAD;
  endsequence

  sequence s_bad_ratio;
    data_ev && dval[`CCP_ST_RATIO] == `CCP_RATIO_BAD && dsel == 2'h0;
  endsequence

  a_mode_serial: assert property (!ma_s && !mb_s |=> ser)
    else $error("serial mode not entered");
  a_mode_static: assert property (ma_s && mb_s |=> !sreg)
    else $error("static mode not entered");
  a_gain_serial: assert property (ser && $stable(pe_s) |=>
    adc_gain_6db_out == $past(pe_s))
    else $error("serial gain wrong");
  a_ovl_path: assert property (adc_clip_l_in || adc_clip_r_in |->
    ##2 adc_overload_flag_out)
    else $error("overload flag late");
  a_static_clk: assert property (mode == CCP_STATIC && !pc_s |=>
    clk_ratio_out == `CCP_RATIO_256)
    else $error("static ratio wrong");
  a_static_mute: assert property (mode == CCP_STATIC &&
    pb_s == `CCP_LVL_HIGH |=> soft_mute_out)
    else $error("static mute missing");
  a_static_fmt: assert property (mode == CCP_STATIC &&
    !pa_s && pe_s |=> audio_fmt_out == `CCP_FMT_I2S)
    else $error("static format wrong");
  a_static_adc: assert property (mode == CCP_STATIC &&
    pd_s == `CCP_LVL_LOW |=> !adc_power_on_out)
    else $error("static ADC not down");
  a_addr_hit: assert property (addr_ev && hit &&
    xfer == `CCP_XFER_STAT |=> sel == CCP_SEL_STAT)
    else $error("status group not selected");
  a_addr_miss: assert property (addr_ev && !hit |=> sel == CCP_DESEL)
    else $error("foreign address kept selection");
  a_sel_hold: assert property (!addr_ev && ser |=> $stable(sel))
    else $error("selection changed without address");
  a_stat_write: assert property (s_stat_wr |=> st_reg == $past(dval)
    ##1 clk_ratio_out == st_reg[`CCP_ST_RATIO] || !sreg)
    else $error("status write lost");
  a_bad_ratio: assert property (s_bad_ratio |=> $stable(st_reg))
    else $error("unused ratio code stored");
  a_desel_write: assert property (sel == CCP_DESEL |=>
    $stable(vol_reg) && $stable(pwr_reg))
    else $error("write while deselected");
endmodule
`default_nettype wire

/* File: rtl/ccp_defines.svh */
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH
// ----------------------------------------
// Address byte
// ----------------------------------------
`define CCP_DEV_ADDR   6'h05
`define CCP_AD_DEV     7:2
`define CCP_AD_XFER    1:0
`define CCP_XFER_DATA  2'h0
`define CCP_XFER_STAT  2'h2
// ----------------------------------------
// Data byte and sub-register selects
// ----------------------------------------
`define CCP_SEL        7:6
`define CCP_VAL        5:0
`define CCP_SEL_STAT   2'h0
`define CCP_SEL_VOL    2'h0
`define CCP_SEL_TONE   2'h1
`define CCP_SEL_DEEM   2'h2
`define CCP_SEL_PWR    2'h3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CCP_ST_RATIO   5:4
`define CCP_ST_FMT     3:1
`define CCP_ST_HPF     0
`define CCP_TN_BASS    5:2
`define CCP_TN_TREB    1:0
`define CCP_DM_DEEM    4:3
`define CCP_DM_MUTE    2
`define CCP_DM_TONE    1:0
`define CCP_PW_ADC     1
`define CCP_PW_DAC     0
// ----------------------------------------
// Codes
// ----------------------------------------
`define CCP_RATIO_BAD  2'h3
`define CCP_RATIO_384  2'h1
`define CCP_RATIO_256  2'h2
`define CCP_FMT_I2S    3'h0
`define CCP_FMT_MSB    3'h4
`define CCP_FMT_L16    3'h5
`define CCP_FMT_L20    3'h7
`define CCP_DEEM_441   2'h2
`define CCP_LVL_LOW    2'h0
`define CCP_LVL_MID    2'h1
`define CCP_LVL_HIGH   2'h2
`define CCP_TONE_FLAT  2'h0
`define CCP_TONE_MAX   2'h3
`define CCP_VOL_SIL    6'h3E
`define CCP_VOL_INF    6'h3F
`define CCP_BASS_MINC  5'h12
`define CCP_BASS_MAXC  5'h18
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CCP_RST_STAT   6'h00
`define CCP_RST_VOL    6'h00
`define CCP_RST_TONE   6'h00
`define CCP_RST_DEEM   6'h00
`define CCP_RST_PWR    6'h03
`define CCP_OVL_HOLD   10'h200
`endif

/* File: rtl/ccp_pkg.sv */
package ccp_pkg;
  // Operating mode from the mode pins
  typedef enum logic [1:0] {CCP_SERIAL, CCP_TEST, CCP_STATIC} ccp_mode_t;
  // Control port selection state
  typedef enum logic [1:0] {CCP_DESEL, CCP_SEL_DATA, CCP_SEL_STAT} ccp_sel_t;
  // One stored control register
  typedef logic [5:0] ccp_reg6_t;
endpackage

/* File: rtl/ccp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Byte hand-off from the link domain
interface ccp_link_if;
  logic [7:0] octet;   // Last complete byte
  logic       is_addr; // Byte came in address phase
  logic       tgl;     // Flips once per byte
  modport src (output octet, output is_addr, output tgl);
  modport dst (input octet, input is_addr, input tgl);
endinterface
`default_nettype wire

/* File: rtl/ccp_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_shift (
  // Link clock and reset
  input wire logic  ctl_port_clk_in,
  input wire logic  nrst_in,
  // Link lines
  input wire logic  ctl_port_phase_in,
  input wire logic  ctl_port_din_in,
  // Byte hand-off
  ccp_link_if.src   link
);
  logic [6:0] shreg;      // Bits gathered so far
  logic [2:0] cnt;        // Bit position in byte
  logic       last_phase; // Phase seen at last edge
  logic [2:0] next_cnt;   // Position of this bit

  // A phase change starts a fresh byte
  assign next_cnt = (ctl_port_phase_in != last_phase) ? 3'h0 : cnt;

  // Shift MSB first; only ever samples the data line
  always_ff @(posedge ctl_port_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shreg        <= 7'h00;
      cnt          <= 3'h0;
      last_phase   <= 1'b1;
      link.octet   <= 8'h00;
      link.is_addr <= 1'b0;
      link.tgl     <= 1'b0;
    end else begin
      last_phase <= ctl_port_phase_in;
      shreg      <= {shreg[5:0], ctl_port_din_in};
      cnt        <= next_cnt + 3'h1;
      // Publish only on the eighth bit; counting wraps for multibyte
      if (next_cnt == 3'h7) begin
        link.octet   <= {shreg, ctl_port_din_in};
        link.is_addr <= !ctl_port_phase_in;
        link.tgl     <= !link.tgl;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ccp_ovl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defines.svh"
module ccp_ovl (
  // Clock and reset
  input wire logic  clk_in,
  input wire logic  nrst_in,
  // Detector and sample strobe
  input wire logic  clip_in,
  input wire logic  fs_tick_in,
  // Stretched flag
  output logic      flag_out
);
  logic [9:0] cnt;      // Sample periods left
  logic [9:0] next_cnt; // Next count

  // Every new clip restarts the full hold
  assign next_cnt = clip_in ? `CCP_OVL_HOLD :
                    (fs_tick_in && cnt != 10'h000) ? cnt - 10'h001 : cnt;

  // Hold counter and flag
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt      <= 10'h000;
      flag_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      flag_out <= (next_cnt != 10'h000);
    end
  end

  a_ovl_hold_on: assert property (@(posedge clk_in)
    disable iff (!nrst_in) (flag_out && !fs_tick_in) |=> flag_out)
    else $error("overload flag dropped without a sample tick");
  a_ovl_restart: assert property (@(posedge clk_in)
    disable iff (!nrst_in) clip_in |=> (cnt == `CCP_OVL_HOLD) && flag_out)
    else $error("overload hold not restarted");
endmodule
`default_nettype wire

/* File: verification/ccp_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccp_mcu_model (
  // Link lines
  output logic clk_out,
  output logic phase_out,
  output logic din_out
);
  // Clock idles high, it stands still between bytes
  initial begin
    clk_out   = 1'b1;
    phase_out = 1'b1;
    din_out   = 1'b0;
  end
  // -------------------------------------------
  // One byte, MSB first, data set on falling edge
  // -------------------------------------------
  task automatic send(input logic [7:0] b, input logic ph);
    #37;
    phase_out = ph;
    #250;
    for (int i = 7; i >= 0; i--) begin
      clk_out = 1'b0;
      din_out = b[i];
      #250;
      clk_out = 1'b1; // Period 500 ns
      #250;
    end
    din_out = ~b[0]; // Released line shows no stale bit
    #4000; // Gap of 8 link periods
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccp_pkg::*;
  logic       clk_in, nrst_in, ma, mb, pa, pc, pe, ser, tick;
  logic [1:0] pb, pd, cl, ratio, deem, tone;
  logic [2:0] fmt, tdb;
  logic [5:0] vol, vdb;
  logic [4:0] bdb;
  logic       hpf, mute, adcp, dacp, gain, ovl, sil, pao, paoe;
  logic [7:0] v;
  ccp_mode_t  mode;
  int         error_cnt, tests_run, cyc;
  wire        lclk, lph, ldin;
  // Serial mode routes the link lines onto the shared pins
  wire  [1:0] b_w = ser ? {lph, 1'b0} : pb;
  wire  [1:0] d_w = ser ? {ldin, 1'b0} : pd;
  wire        c_w = ser ? lclk : pc;
  ccp_mcu_model mcu (.clk_out(lclk), .phase_out(lph), .din_out(ldin));
  ccp_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .mode_sel_a_in(ma),
    .mode_sel_b_in(mb), .multi_pin_a_in(pa), .multi_pin_a_out(pao),
    .multi_pin_a_oe_out(paoe), .multi_pin_b_in(b_w), .multi_pin_c_in(c_w),
    .multi_pin_d_in(d_w), .multi_pin_e_in(pe), .adc_clip_l_in(cl[1]),
    .adc_clip_r_in(cl[0]), .fs_tick_in(tick), .mode_out(mode),
    .clk_ratio_out(ratio), .audio_fmt_out(fmt), .hpf_enable_out(hpf),
    .vol_atten_out(vol), .vol_db_out(vdb), .vol_silent_out(sil),
    .bass_db_out(bdb), .treble_db_out(tdb), .deemph_sel_out(deem),
    .soft_mute_out(mute), .tone_set_out(tone), .adc_power_on_out(adcp),
    .dac_power_on_out(dacp), .adc_gain_6db_out(gain),
    .adc_overload_flag_out(ovl));
  always #5 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_in) tick <= 1'b1;
      @(posedge clk_in) tick <= 1'b0;
    end
  endtask
  function automatic logic [5:0] edb(input logic [5:0] c);
    return (c >= 6'h3E) ? 6'h3F : ((c == 6'h00) ? 6'h00 : c - 6'h01);
  endfunction
  function automatic logic [2:0] sfmt(input logic a, input logic e);
    return 3'(16'h5704 >> (4 * {a, e}));
  endfunction
  // Bass and treble in dB: flat none, min caps at 18, max at 24
  function automatic logic [7:0] etone(input logic [5:0] b,
                                       input logic [1:0] m);
    logic [4:0] x;
    x = {b[5:2], 1'b0};
    if (x > ((m == 2'h3) ? 5'h18 : 5'h12)) x = (m == 2'h3) ? 5'h18 : 5'h12;
    return (m == 2'h0) ? 8'h00 : {x, b[1:0], 1'b0};
  endfunction
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // -------------------------------------------
  // Main sequence
  // -------------------------------------------
  initial begin
    clk_in = 1'b0;
    nrst_in = 1'b0;
    {ma, mb, pa, pc, pe, tick, cl, pb, pd} = '0;
    ser = 1'b1; // Link lines on the shared pins from the start
    void'($urandom(18));
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({adcp, dacp}, 8'h03);
    chk(mode, CCP_SERIAL);
    mcu.send(8'h16, 1'b0);
    for (int i = 0; i < 5; i++) begin
      v = {2'h0, 6'($urandom)};
      if (v[5:4] == 2'h3) v[5:4] = 2'h0;
      if (i == 0) v = 8'h26;
      mcu.send(v, 1'b1);
      chk({ratio, fmt, hpf}, v);
    end
    mcu.send(8'h3F, 1'b1);
    chk({ratio, fmt, hpf}, v);
    mcu.send(8'h14, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[5:0] = (i == 0) ? 6'h01 : ((i == 1) ? 6'h3E : v[5:0]);
      mcu.send({2'h0, v[5:0]}, 1'b1);
      chk(vol, v[5:0]);
      chk({sil, vdb}, {v[5:0] >= 6'h3E, edb(v[5:0])});
      mcu.send({3'h4, v[4:2], 2'(i)}, 1'b1);
      chk({deem, mute, tone}, {v[4:2], 2'(i)});
      mcu.send({2'h1, ~v[5:0]}, 1'b1);
      chk({bdb, tdb}, etone(~v[5:0], 2'(i)));
      mcu.send({6'h30, v[1:0]}, 1'b1);
      chk({adcp, dacp}, v[1:0]);
    end
    foreach (v[j]) if (j < 2) begin
      mcu.send(j ? 8'h15 : 8'h1C, 1'b0);
      mcu.send({2'h0, ~v[5:0]}, 1'b1);
      chk(vol, v[5:0]);
    end
    for (int i = 0; i < 3; i++) begin
      pe <= i[0];
      repeat (6) @(posedge clk_in);
      chk(gain, i[0]);
    end
    cl <= 2'h2;
    tk(1);
    cl <= 2'h0;
    @(posedge clk_in);
    chk({ovl, pao, paoe}, 3'h7);
    tk(300);
    cl <= 2'h1;
    tk(1);
    cl <= 2'h0;
    tk(510);
    chk(ovl, 1'b1);
    tk(2);
    repeat (4) @(posedge clk_in);
    chk({ovl, pao}, 2'h0);
    mb <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk({mode, adcp, dacp, paoe}, {CCP_TEST, v[1:0], 1'b0});
    ser <= 1'b0;
    {ma, mb} <= 2'h3;
    for (int i = 0; i < 24; i++) begin
      {pa, pe, pc} <= 3'($urandom);
      pb <= 2'($urandom % 3);
      pd <= 2'($urandom % 3);
      repeat (6) @(posedge clk_in);
      chk({mode, paoe}, {CCP_STATIC, 1'b0});
      chk(fmt, sfmt(pa, pe));
      chk(ratio, pc ? 2'h1 : 2'h2);
      chk({deem, mute}, (pb == 0) ? 0 : ((pb == 1) ? 3'h4 : 3'h1));
      chk({adcp, gain}, (pd == 0) ? 0 : ((pd == 1) ? 2'h3 : 2'h2));
    end
    summarize();
  end
endmodule
`default_nettype wire
